// *** verilog/gyro_hub_regs.vh ***
// Function
// - Aux master burst-reads six bytes: X, Y, Z, two bytes each.
// - Aux master fetches samples alone and hands them to the motion coprocessor.
// - In pass-through the host is sole master, addressing the accelerometer directly.
// - Pass-through disables aux master logic, joins the aux data line to the host data line and releases the aux clock.
// - Software picks relaxation or X, Y, Z gyro oscillator as PLL reference.
// - External 32.768kHz or 19.2MHz square wave is a selectable PLL source.
// - After reset the internal oscillator is used until software selects another.
// - A clock output lets the accelerometer sample in step with on-chip sensors.
// - That clock output runs at a fixed one megahertz.
// - Sensor data registers hold latest gyro and temperature, read-only, readable anytime.
// - A 512-byte FIFO whose contents are chosen by a FIFO configuration setting.
// - A FIFO counter always reports how many valid bytes the FIFO holds.
// - Consecutive reads of the FIFO data location return successive bytes.
// - Temperature is readable from the FIFO and the sensor data registers.
// - Interrupt config selects pin mode, latching, clearing method and trigger events.
// - Interrupt pin is push-pull or open-drain.
// - Interrupt event when the clock generator locks after a source switch.
// - Interrupt event when the motion coprocessor signals completion.
// - Interrupt event when new data is ready in FIFO or data registers.
// - Interrupt event when the accelerometer fails to acknowledge on the aux bus.
// - Pending interrupt events are readable in an interrupt status register.
`ifndef GYRO_HUB_REGS_VH
`define GYRO_HUB_REGS_VH
`define CLK_HZ          125000000
`define SYNC_OUT_HZ     1000000
`define AUX_SCL_HZ      400000
`define A_CLK_CTRL      8'h00
`define A_AUX_CFG       8'h04
`define A_FIFO_CFG      8'h08
`define A_INT_CFG       8'h0c
`define A_INT_STATUS    8'h10
`define A_GYRO_X        8'h14
`define A_GYRO_Y        8'h18
`define A_GYRO_Z        8'h1c
`define A_TEMP          8'h20
`define A_ACCEL_X       8'h24
`define A_ACCEL_Y       8'h28
`define A_ACCEL_Z       8'h2c
`define A_FIFO_COUNT    8'h30
`define A_FIFO_DATA     8'h34
`define CLK_SEL_RELAX   3'h0
`define CLK_SEL_GYRO_X  3'h1
`define CLK_SEL_GYRO_Y  3'h2
`define CLK_SEL_GYRO_Z  3'h3
`define CLK_SEL_EXT_32K 3'h4
`define CLK_SEL_EXT_19M 3'h5
`define CC_MASTER_BIT   4
`define CC_PASS_BIT     5
`define IC_OPEN_DRAIN   0
`define IC_ACT_LOW      1
`define IC_LATCH        2
`define IC_CLR_ANY_RD   3
`define IC_EN_LSB       8
`define EV_LOCK         0
`define EV_MOTION_DONE  1
`define EV_DATA_RDY     2
`define EV_AUX_NACK     3
`define RST_AUX_CFG     32'h0000_0000
`define RST_FIFO_CFG    4'h0
`define RST_INT_CFG     32'h0000_0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// *** verilog/gyro_hub_clock_irq_fifo_ctrl.v ***
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "gyro_hub_regs.vh"
module gyro_hub_clock_irq_fifo_ctrl #(
  parameter FIFO_DEPTH = 512,
  parameter FIFO_AW    = 9
) (
  input  wire        ref_clk_i,
  input  wire        reset_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output reg  [2:0]  clk_src_sel_o,
  input  wire        pll_lock_i,
  input  wire [15:0] gyro_x_i,
  input  wire [15:0] gyro_y_i,
  input  wire [15:0] gyro_z_i,
  input  wire [15:0] temp_i,
  input  wire [15:0] aux_adc_i,
  input  wire        sample_valid_i,
  input  wire        motion_done_i,
  output reg  [47:0] accel_data_o,
  output reg         accel_valid_o,
  output reg         accel_sync_clock_out_o,
  input  wire        aux_serial_data_i,
  output wire        aux_serial_data_o,
  output reg         aux_serial_data_oe_o,
  input  wire        aux_serial_clock_i,
  output wire        aux_serial_clock_o,
  output reg         aux_serial_clock_oe_o,
  input  wire        host_sda_i,
  output wire        host_sda_o,
  output reg         host_sda_oe_o,
  output reg         int_o,
  output reg         int_oe_o
);
  localparam SYNC_DIV = `CLK_HZ / `SYNC_OUT_HZ;
  localparam QTR      = `CLK_HZ / (4 * `AUX_SCL_HZ);
  localparam M_IDLE   = 2'd0;
  localparam M_START  = 2'd1;
  localparam M_BIT    = 2'd2;
  localparam M_STOP   = 2'd3;

  // Two-flop synchronisers for pins and the PLL lock
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
    end else begin
      s1_q <= {pll_lock_i, host_sda_i, aux_serial_clock_i, aux_serial_data_i};
      s2_q <= s1_q;
    end
  end
  wire lock_s = s2_q[3];
  wire host_sda_s = s2_q[2];
  wire aux_scl_s = s2_q[1];
  wire aux_sda_s = s2_q[0];

  // Register file
  reg [5:0]  ctrl_q;
  reg [31:0] aux_cfg_q;
  reg [3:0]  fifo_cfg_q;
  reg [31:0] int_cfg_q;
  reg [3:0]  int_st_q;
  reg [15:0] gx_q, gy_q, gz_q, temp_q;
  reg [7:0]  fifo_mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW-1:0] wr_ptr_q, rd_ptr_q;
  reg [FIFO_AW:0]   count_q;
  wire pass_en = ctrl_q[`CC_PASS_BIT];
  wire mst_en = ctrl_q[`CC_MASTER_BIT] & ~pass_en;

  // AXI4-Lite write: address and data taken in either order
  reg        aw_full_q, w_full_q;
  reg [7:0]  aw_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;
  assign s_axi_awready_o = ~aw_full_q & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_full_q & ~s_axi_bvalid_o;
  wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid_o;
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire wr_ctrl = do_wr & (aw_q == `A_CLK_CTRL);
  wire [31:0] ctrl_new = ({26'h0, ctrl_q} & ~wmask) | (wd_q & wmask);
  reg wr_ok;
  always @* begin
    case (aw_q)
      `A_CLK_CTRL, `A_AUX_CFG, `A_FIFO_CFG, `A_INT_CFG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
      ctrl_q <= {3'h0, `CLK_SEL_RELAX};
      aux_cfg_q <= `RST_AUX_CFG;
      fifo_cfg_q <= `RST_FIFO_CFG;
      int_cfg_q <= `RST_INT_CFG;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_full_q <= 1'b1;
        aw_q <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_full_q <= 1'b1;
        wd_q <= s_axi_wdata_i;
        ws_q <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (aw_q)
          `A_CLK_CTRL: ctrl_q <= ctrl_new[5:0];
          `A_AUX_CFG: aux_cfg_q <= (aux_cfg_q & ~wmask) | (wd_q & wmask);
          `A_FIFO_CFG: begin
            if (ws_q[0]) fifo_cfg_q <= wd_q[3:0];
          end
          `A_INT_CFG: int_cfg_q <= (int_cfg_q & ~wmask) | (wd_q & wmask);
          default: ;
        endcase
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Source change is applied only after the write, so lock tracking can rearm
  reg lock_wait_q, lock_d1_q;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_src_sel_o <= `CLK_SEL_RELAX;
      lock_wait_q <= 1'b0;
      lock_d1_q <= 1'b0;
    end else begin
      clk_src_sel_o <= ctrl_q[2:0];
      lock_d1_q <= lock_s;
      if (clk_src_sel_o != ctrl_q[2:0])
        lock_wait_q <= 1'b1;
      else if (lock_s & ~lock_d1_q)
        lock_wait_q <= 1'b0;
    end
  end
  wire ev_lock = lock_wait_q & lock_s & ~lock_d1_q;

  // AXI4-Lite read; one read outstanding
  wire rd_take = s_axi_arvalid_i & s_axi_arready_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  wire fifo_empty = (count_q == {(FIFO_AW+1){1'b0}});
  wire pop = rd_take & ({s_axi_araddr_i[7:2], 2'b00} == `A_FIFO_DATA) & ~fifo_empty;
  reg [31:0] rmux;
  reg        rerr;
  always @* begin
    rerr = 1'b0;
    case ({s_axi_araddr_i[7:2], 2'b00})
      `A_CLK_CTRL: rmux = {26'h0, ctrl_q};
      `A_AUX_CFG: rmux = aux_cfg_q;
      `A_FIFO_CFG: rmux = {28'h0, fifo_cfg_q};
      `A_INT_CFG: rmux = int_cfg_q;
      `A_INT_STATUS: rmux = {28'h0, int_st_q};
      `A_GYRO_X: rmux = {16'h0, gx_q};
      `A_GYRO_Y: rmux = {16'h0, gy_q};
      `A_GYRO_Z: rmux = {16'h0, gz_q};
      `A_TEMP: rmux = {16'h0, temp_q};
      `A_ACCEL_X: rmux = {16'h0, accel_data_o[47:32]};
      `A_ACCEL_Y: rmux = {16'h0, accel_data_o[31:16]};
      `A_ACCEL_Z: rmux = {16'h0, accel_data_o[15:0]};
      `A_FIFO_COUNT: rmux = {{(31-FIFO_AW){1'b0}}, count_q};
      `A_FIFO_DATA: rmux = fifo_empty ? 32'h0 : {24'h0, fifo_mem[rd_ptr_q]};
      default: begin
        rmux = 32'h0000_0000;
        rerr = 1'b1;
      end
    endcase
  end
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rmux;
      s_axi_rresp_o <= rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // 1 MHz sync clock; odd divide gives a 62/63 duty split
  reg [7:0] sdiv_q;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sdiv_q <= 8'h00;
      accel_sync_clock_out_o <= 1'b0;
    end else begin
      sdiv_q <= (sdiv_q == SYNC_DIV - 1) ? 8'h00 : sdiv_q + 8'h01;
      accel_sync_clock_out_o <= (sdiv_q < SYNC_DIV / 2);
    end
  end

  // Aux bus master: S, addr+W, reg, Sr, addr+R, six data bytes, P
  reg [1:0] mst_q, qtr_q;
  reg [6:0] tcnt_q;
  reg [3:0] bidx_q, bitn_q;
  reg [7:0] rx_q;
  reg [47:0] abuf_q;
  reg sda_low_q, trig_q, ev_nack_q;
  wire scl_low = (mst_q != M_IDLE) & ((qtr_q == 2'd0) | (qtr_q == 2'd3 & mst_q != M_STOP));
  // Accelerometer may stretch the clock while it is released
  wire stretch = ~scl_low & ~aux_scl_s & (mst_q != M_IDLE);
  wire tick = (tcnt_q == QTR - 1) & ~stretch;
  wire is_wr = (bidx_q < 4'd3);
  wire [3:0] nbit = (bitn_q == 4'd8) ? 4'd0 : bitn_q + 4'd1;
  reg [7:0] txb;
  always @* begin
    case (bidx_q)
      4'd0: txb = {aux_cfg_q[6:0], 1'b0};
      4'd1: txb = aux_cfg_q[15:8];
      default: txb = {aux_cfg_q[6:0], 1'b1};
    endcase
  end
  // Drive low for a zero write bit, or for the ACK of every read byte but the last
  wire drv0 = is_wr ? (nbit != 4'd8 & ~txb[3'd7 - nbit[2:0]])
                    : (nbit == 4'd8 & bidx_q != 4'd8);

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mst_q <= M_IDLE;
      qtr_q <= 2'd0;
      tcnt_q <= 7'd0;
      bidx_q <= 4'd0;
      bitn_q <= 4'd0;
      rx_q <= 8'h00;
      abuf_q <= 48'h0;
      sda_low_q <= 1'b0;
      trig_q <= 1'b0;
      ev_nack_q <= 1'b0;
      accel_valid_o <= 1'b0;
      accel_data_o <= 48'h0;
    end else begin
      ev_nack_q <= 1'b0;
      accel_valid_o <= 1'b0;
      if (sample_valid_i & mst_en) trig_q <= 1'b1;
      if (~mst_en) begin
        mst_q <= M_IDLE;
        sda_low_q <= 1'b0;
        trig_q <= 1'b0;
        qtr_q <= 2'd0;
        tcnt_q <= 7'd0;
      end else if (mst_q == M_IDLE) begin
        if (trig_q) begin
          trig_q <= 1'b0;
          mst_q <= M_START;
          bidx_q <= 4'd0;
          qtr_q <= 2'd0;
          tcnt_q <= 7'd0;
        end
      end else if (~tick) begin
        if (~stretch) tcnt_q <= tcnt_q + 7'd1;
      end else begin
        tcnt_q <= 7'd0;
        qtr_q <= qtr_q + 2'd1;
        case (mst_q)
          M_START: begin
            if (qtr_q == 2'd1) sda_low_q <= 1'b1;
            if (qtr_q == 2'd3) begin
              mst_q <= M_BIT;
              bitn_q <= 4'd0;
              sda_low_q <= is_wr & ~txb[7];
            end
          end
          M_BIT: begin
            if (qtr_q == 2'd2) begin
              if (bitn_q != 4'd8) rx_q <= {rx_q[6:0], aux_sda_s};
              else if (is_wr & aux_sda_s) begin
                ev_nack_q <= 1'b1;
                mst_q <= M_STOP;
              end
            end
            if (qtr_q == 2'd3) begin
              bitn_q <= nbit;
              sda_low_q <= drv0;
              if (bitn_q == 4'd8) begin
                if (~is_wr) abuf_q <= {abuf_q[39:0], rx_q};
                if (bidx_q == 4'd1) begin
                  mst_q <= M_START;
                  sda_low_q <= 1'b0;
                end else if (bidx_q == 4'd8) begin
                  mst_q <= M_STOP;
                  sda_low_q <= 1'b1;
                  accel_data_o <= {abuf_q[39:0], rx_q};
                  accel_valid_o <= 1'b1;
                end
                bidx_q <= bidx_q + 4'd1;
                if (bidx_q != 4'd1 & bidx_q != 4'd8) sda_low_q <= bidx_q < 4'd2 ?
                  ~aux_cfg_q[15] : 1'b0;
              end
            end
          end
          M_STOP: begin
            if (qtr_q == 2'd0) sda_low_q <= 1'b1;
            if (qtr_q == 2'd2) sda_low_q <= 1'b0;
            if (qtr_q == 2'd3) mst_q <= M_IDLE;
          end
          default: mst_q <= M_IDLE;
        endcase
      end
    end
  end

  // Pass-through switch; first side pulled low owns SDA, holdoff hides sync lag
  reg       own_host_q, own_aux_q;
  reg [2:0] hold_q;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      own_host_q <= 1'b0;
      own_aux_q <= 1'b0;
      hold_q <= 3'd0;
    end else if (~pass_en) begin
      own_host_q <= 1'b0;
      own_aux_q <= 1'b0;
      hold_q <= 3'd0;
    end else if (own_host_q) begin
      if (host_sda_s) begin
        own_host_q <= 1'b0;
        hold_q <= 3'd4;
      end
    end else if (own_aux_q) begin
      if (aux_sda_s) begin
        own_aux_q <= 1'b0;
        hold_q <= 3'd4;
      end
    end else if (hold_q != 3'd0) begin
      hold_q <= hold_q - 3'd1;
    end else if (~host_sda_s) begin
      own_host_q <= 1'b1;
    end else if (~aux_sda_s) begin
      own_aux_q <= 1'b1;
    end
  end
  assign aux_serial_data_o = 1'b0;
  assign aux_serial_clock_o = 1'b0;
  assign host_sda_o = 1'b0;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aux_serial_data_oe_o <= 1'b0;
      aux_serial_clock_oe_o <= 1'b0;
      host_sda_oe_o <= 1'b0;
    end else begin
      aux_serial_data_oe_o <= pass_en ? (own_host_q & ~host_sda_s) : sda_low_q;
      aux_serial_clock_oe_o <= pass_en ? 1'b0 : scl_low;
      host_sda_oe_o <= own_aux_q & ~aux_sda_s;
    end
  end

  // Sample capture and FIFO serializer over 16 byte slots
  reg [127:0] snap_q;
  reg         ser_q;
  reg [3:0]   slot_q;
  reg         slot_sel;
  always @* begin
    slot_sel = fifo_cfg_q[0];
    if (slot_q >= 4'd14) slot_sel = fifo_cfg_q[3];
    else if (slot_q >= 4'd12) slot_sel = fifo_cfg_q[2];
    else if (slot_q >= 4'd6) slot_sel = fifo_cfg_q[1];
  end
  wire full = (count_q == FIFO_DEPTH);
  wire push = ser_q & slot_sel & ~full;
  wire [6:0] sbase = {slot_q, 3'b000};
  always @(posedge ref_clk_i) begin
    if (push) fifo_mem[wr_ptr_q] <= snap_q[7'd120 - sbase +: 8];
  end
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      snap_q <= 128'h0;
      ser_q <= 1'b0;
      slot_q <= 4'd0;
      gx_q <= 16'h0;
      gy_q <= 16'h0;
      gz_q <= 16'h0;
      temp_q <= 16'h0;
      wr_ptr_q <= {FIFO_AW{1'b0}};
      rd_ptr_q <= {FIFO_AW{1'b0}};
      count_q <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (sample_valid_i) begin
        gx_q <= gyro_x_i;
        gy_q <= gyro_y_i;
        gz_q <= gyro_z_i;
        temp_q <= temp_i;
        snap_q <= {gyro_x_i, gyro_y_i, gyro_z_i, accel_data_o, temp_i, aux_adc_i};
        ser_q <= 1'b1;
        slot_q <= 4'd0;
      end else if (ser_q) begin
        slot_q <= slot_q + 4'd1;
        if (slot_q == 4'd15) ser_q <= 1'b0;
      end
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push & ~pop) count_q <= count_q + 1'b1;
      else if (pop & ~push) count_q <= count_q - 1'b1;
    end
  end

  // Interrupt status: set wins over clear
  wire [3:0] ev_raw;
  assign ev_raw[`EV_LOCK] = ev_lock;
  assign ev_raw[`EV_MOTION_DONE] = motion_done_i;
  assign ev_raw[`EV_DATA_RDY] = sample_valid_i | accel_valid_o;
  assign ev_raw[`EV_AUX_NACK] = ev_nack_q;
  wire [3:0] ev = ev_raw & int_cfg_q[`IC_EN_LSB +: 4];
  wire st_rd = rd_take & ({s_axi_araddr_i[7:2], 2'b00} == `A_INT_STATUS);
  wire clr = int_cfg_q[`IC_CLR_ANY_RD] ? rd_take : st_rd;
  wire act = |int_st_q;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_st_q <= 4'h0;
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
    end else begin
      if (int_cfg_q[`IC_LATCH])
        int_st_q <= ev | (clr ? 4'h0 : int_st_q);
      else
        int_st_q <= ev;
      if (int_cfg_q[`IC_OPEN_DRAIN]) begin
        int_o <= 1'b0;
        int_oe_o <= act;
      end else begin
        int_o <= act ^ int_cfg_q[`IC_ACT_LOW];
        int_oe_o <= 1'b1;
      end
    end
  end
endmodule

// *** tb/gyro_hub_asserts.sv ***
`timescale 1ns/10ps
module gyro_hub_asserts (
  input wire        ref_clk_i,
  input wire        reset_i,
  input wire [2:0]  clk_src_sel_o,
  input wire        accel_sync_clock_out_o,
  input wire        aux_serial_data_o,
  input wire        aux_serial_data_oe_o,
  input wire        aux_serial_clock_o,
  input wire        aux_serial_clock_oe_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o
);
  logic [7:0] period_q;
  logic [7:0] hold_q;
  logic       prev_q;
  logic       seen_q;
  // Saturating counters, so a stuck output shows as a large value
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      period_q <= 8'h00;
      hold_q   <= 8'h00;
      prev_q   <= 1'b0;
      seen_q   <= 1'b0;
    end else begin
      prev_q   <= accel_sync_clock_out_o;
      hold_q   <= (accel_sync_clock_out_o != prev_q) ? 8'h01 : hold_q + {7'h00, hold_q != 8'hff};
      if (accel_sync_clock_out_o && !prev_q) begin
        period_q <= 8'h01;
        seen_q   <= 1'b1;
      end else begin
        period_q <= period_q + {7'h00, period_q != 8'hff};
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  clk_src_start_a: assert property ($fell(reset_i) |-> clk_src_sel_o == 3'h0)
    else $error("clock source not internal after reset");
  clk_src_legal_a: assert property (clk_src_sel_o <= 3'h5)
    else $error("clock source select out of range");
  sync_period_a: assert property ($rose(accel_sync_clock_out_o) && seen_q |-> period_q == 8'h7d)
    else $error("sync clock period wrong");
  sync_toggle_a: assert property (hold_q < 8'h40)
    else $error("sync clock stopped");
  aux_data_od_a: assert property (aux_serial_data_oe_o |-> !aux_serial_data_o)
    else $error("aux data driven high");
  aux_clk_od_a: assert property (aux_serial_clock_oe_o |-> !aux_serial_clock_o)
    else $error("aux clock driven high");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped or changed");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped or changed");
endmodule
bind gyro_hub_clock_irq_fifo_ctrl gyro_hub_asserts gyro_hub_asserts_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_src_sel_o(clk_src_sel_o),
  .accel_sync_clock_out_o(accel_sync_clock_out_o), .aux_serial_data_o(aux_serial_data_o),
  .aux_serial_data_oe_o(aux_serial_data_oe_o), .aux_serial_clock_o(aux_serial_clock_o),
  .aux_serial_clock_oe_o(aux_serial_clock_oe_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o));

// *** tb/accel_model.sv ***
`timescale 1ns/10ps
module accel_model (
  input  wire        scl_i,
  input  wire        sda_i,
  input  wire        nack_i,
  input  wire [47:0] sample_i,
  output reg         sda_low_o
);
  logic [7:0] byte_q;
  task automatic get_byte();
    for (int b = 0; b < 8; b++) begin
      @(posedge scl_i);
      byte_q = {byte_q[6:0], sda_i};
    end
  endtask
  task automatic ack(input logic on);
    @(negedge scl_i);
    sda_low_o = on;
    @(negedge scl_i);
    sda_low_o = 1'b0;
  endtask
  // Any start, repeated or not, restarts address decoding
  initial begin
    sda_low_o = 1'b0;
    forever begin
      @(negedge sda_i iff scl_i === 1'b1);
      get_byte();
      ack(!nack_i);
      if (!nack_i && byte_q[0]) begin
        for (int k = 5; k >= 0; k--) begin
          for (int b = 7; b >= 0; b--) begin
            sda_low_o = !sample_i[k*8+b];
            @(negedge scl_i);
          end
          sda_low_o = 1'b0;
          @(posedge scl_i);
          @(negedge scl_i);
        end
      end else if (!nack_i) begin
        get_byte();
        ack(1'b1);
      end
    end
  end
endmodule

// *** tb/tb_gyro_hub_clock_irq_fifo_ctrl.sv ***
`timescale 1ns/10ps
`include "gyro_hub_regs.vh"
module tb_gyro_hub_clock_irq_fifo_ctrl;
  localparam logic [47:0] accel_word = 48'h1a2b_3c4d_5e6f;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [15:0] gx = 0, gy = 0, gz = 0, temp = 0, aux_adc = 0, pad;
  logic        pll_lock = 0, sample_valid = 0, motion_done = 0, nack = 0;
  logic        host_drv = 1, link_low = 0, valid_seen = 0;
  wire         awready, wready, bvalid, arready, rvalid, accel_valid, sync_out;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  clk_sel;
  wire  [47:0] accel_data;
  wire         ad_o, ad_oe, ac_o, ac_oe, hs_o, hs_oe, int_pin, int_oe, model_low;
  wire         aux_sda = !(ad_oe && !ad_o) && !model_low && !link_low;
  wire         aux_scl = !(ac_oe && !ac_o);
  wire         host_sda = host_drv && !(hs_oe && !hs_o);
  logic [63:0] exp_q[$];
  logic [47:0] acc_q[$];
  logic [63:0] e;
  int          n_errors = 0, checks = 0, seed = 23;
  always #4 ref_clk_i = ~ref_clk_i;
  gyro_hub_clock_irq_fifo_ctrl #(.FIFO_DEPTH(512), .FIFO_AW(9)) gyro_hub_clock_irq_fifo_ctrl_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .clk_src_sel_o(clk_sel), .pll_lock_i(pll_lock),
    .gyro_x_i(gx), .gyro_y_i(gy), .gyro_z_i(gz), .temp_i(temp), .aux_adc_i(aux_adc),
    .sample_valid_i(sample_valid), .motion_done_i(motion_done), .accel_data_o(accel_data),
    .accel_valid_o(accel_valid), .accel_sync_clock_out_o(sync_out),
    .aux_serial_data_i(aux_sda), .aux_serial_data_o(ad_o), .aux_serial_data_oe_o(ad_oe),
    .aux_serial_clock_i(aux_scl), .aux_serial_clock_o(ac_o), .aux_serial_clock_oe_o(ac_oe),
    .host_sda_i(host_sda), .host_sda_o(hs_o), .host_sda_oe_o(hs_oe),
    .int_o(int_pin), .int_oe_o(int_oe));
  accel_model accel_model_i (.scl_i(aux_scl), .sda_i(aux_sda), .nack_i(nack),
    .sample_i(accel_word), .sda_low_o(model_low));
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta = 1'b0, tw = 1'b0, hit;
    @(posedge ref_clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge ref_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    do begin
      @(negedge ref_clk_i);
      hit = bvalid;
      @(posedge ref_clk_i);
    end while (!hit);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic hit;
    exp_q.push_back({m, x & m});
    @(posedge ref_clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      hit = arready;
      @(posedge ref_clk_i);
    end while (!hit);
    arvalid <= 1'b0;
    do begin
      @(negedge ref_clk_i);
      hit = rvalid;
      @(posedge ref_clk_i);
    end while (!hit);
    rready <= 1'b0;
  endtask
  task automatic sample();
    @(posedge ref_clk_i);
    {gx, gy} <= $random(seed);
    {gz, temp} <= $random(seed);
    {aux_adc, pad} <= $random(seed);
    sample_valid <= 1'b1;
    @(posedge ref_clk_i);
    sample_valid <= 1'b0;
  endtask
  always @(posedge ref_clk_i) begin
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      check({16'h0, rdata & e[63:32]}, {16'h0, e[31:0]});
    end
    if (accel_valid && !valid_seen) check(accel_data, acc_q.pop_front());
    valid_seen <= accel_valid;
  end
  initial begin
    #760000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    check({45'h0, clk_sel}, {45'h0, `CLK_SEL_RELAX});
    wr(`A_INT_CFG, 32'h0000_0f04);
    for (int s = 0; s < 6; s++) begin
      wr(`A_CLK_CTRL, s);
      repeat (2) @(posedge ref_clk_i);
      check({45'h0, clk_sel}, s);
    end
    pll_lock <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    check({46'h0, int_oe, int_pin}, 48'h3);
    rd(`A_INT_STATUS, 32'h1, 32'h1);
    motion_done <= 1'b1;
    @(posedge ref_clk_i);
    motion_done <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    check({46'h0, int_oe, int_pin}, 48'h3);
    rd(`A_INT_STATUS, 32'h2, 32'h2);
    wr(`A_INT_CFG, 32'h0000_0f07);
    wr(`A_FIFO_CFG, 32'hf);
    sample();
    repeat (4) @(posedge ref_clk_i);
    check({46'h0, int_oe, int_pin}, 48'h2);
    rd(`A_INT_STATUS, 32'h4, 32'h4);
    repeat (2) @(posedge ref_clk_i);
    check({47'h0, int_oe}, 48'h0);
    rd(`A_GYRO_X, 32'hffff, gx);
    rd(`A_TEMP, 32'hffff, temp);
    wr(`A_GYRO_X, ~{16'h0, gx});
    rd(`A_GYRO_X, 32'hffff, gx);
    rd(`A_FIFO_COUNT, 32'h3ff, 32'd16);
    rd(`A_FIFO_DATA, 32'hff, gx[15:8]);
    rd(`A_FIFO_DATA, 32'hff, gx[7:0]);
    rd(`A_FIFO_COUNT, 32'h3ff, 32'd14);
    wr(`A_FIFO_CFG, 32'h0);
    wr(`A_INT_CFG, 32'h0000_0b07);
    acc_q.push_back(accel_word);
    wr(`A_AUX_CFG, 32'h10);
    wr(`A_CLK_CTRL, 32'h15);
    sample();
    for (int n = 0; n < 40000 && accel_valid !== 1'b1; n++) @(posedge ref_clk_i);
    rd(`A_ACCEL_X, 32'hffff, accel_word[47:32]);
    nack <= 1'b1;
    sample();
    for (int n = 0; n < 40000 && int_oe !== 1'b1; n++) @(posedge ref_clk_i);
    rd(`A_INT_STATUS, 32'h8, 32'h8);
    wr(`A_AUX_CFG, 32'h20);
    wr(`A_CLK_CTRL, 32'h25);
    // Host data toggles every 40 ns (5 cycles) while passing through
    for (int i = 0; i < 4; i++) begin
      host_drv <= i[0];
      repeat (5) @(posedge ref_clk_i);
      check({46'h0, ad_oe, ac_oe}, {46'h0, !i[0], 1'b0});
    end
    link_low <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    check({46'h0, hs_oe, hs_o}, 48'h2);
    link_low <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    stop_test();
  end
endmodule
